/* File: rtl/flash_command_status_regs.v */
/*
  Register front end of the on-chip flash controller: command decode with two-step
  unlock, page and mass erase start, status readback, auxiliary area select and the
  set-only sector guard mask, reached over AXI4-Lite.
  Assumes the page select register, the program path and the flash array sit outside
  on the same clock, and that the array reports completion with a one-cycle done pulse.
*/
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "flash_ctl_defines.vh"
// Notes on behaviour
// - Writes to the shared command/status word are commands; reads there return status.
// - The controller unlocks only after the first unlock code followed by the second.
// - While unlocked, the page erase code starts an erase of the selected page.
// - While unlocked, the mass erase code starts an erase of the whole array.
// - Any unlisted code, or a listed code out of order, locks the controller.
// - Status bit 7 reads 1 while unlocked and 0 while locked, and 0 after reset.
// - The operation field reads idle, program, page erase or mass erase patterns.
// - Status reads have no side effect at any time and reserved bit 6 reads 0.
// - With the auxiliary select set, the information area covers the low program range.
// - Sector guard bits can only be set by writes; zeros leave them unchanged.
// - A set sector guard bit refuses programming and erasure of that sector.
// - The controller leaves reset locked.
// - Writing zero to the command word leaves programming mode and locks.
// - A finished page erase relocks the controller on its own.
module flash_command_status_regs (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire [31:0] awaddr_in,
  input wire awvalid_in,
  output wire awready_out,
  input wire [31:0] wdata_in,
  input wire [3:0] wstrb_in,
  input wire wvalid_in,
  output wire wready_out,
  output wire [1:0] bresp_out,
  output wire bvalid_out,
  input wire bready_in,
  input wire [31:0] araddr_in,
  input wire arvalid_in,
  output wire arready_out,
  output wire [31:0] rdata_out,
  output wire [1:0] rresp_out,
  output wire rvalid_out,
  input wire rready_in,
  input wire [5:0] page_select_in,
  input wire prog_req_in,
  input wire [23:0] prog_addr_in,
  input wire [23:0] fetch_addr_in,
  input wire flash_done_in,
  output reg program_start_out,
  output reg [23:0] program_addr_out,
  output reg prog_refused_out,
  output reg page_erase_start_out,
  output reg [5:0] erase_page_out,
  output reg mass_erase_start_out,
  output reg erase_refused_out,
  output reg aux_area_hit_out,
  output reg [7:0] sector_guard_out,
  output reg unlocked_out
);
  localparam [1:0] ST_LOCKED = 2'h0;
  localparam [1:0] ST_FIRST_SEEN = 2'h1;
  localparam [1:0] ST_UNLOCKED = 2'h2;
  localparam [1:0] SEL_NONE = 2'h0;
  localparam [1:0] SEL_CMD = 2'h1;
  localparam [1:0] SEL_CTL = 2'h2;
  localparam [1:0] SEL_GUARD = 2'h3;

  // Byte address of a printed register index
  function [31:0] reg_addr;
    input [23:0] idx;
    begin
      reg_addr = {6'h00, idx, 2'h0};
    end
  endfunction

  // Sector that holds a program address
  function [2:0] sector_of;
    input [23:0] addr;
    begin
      sector_of = addr[`SECTOR_MSB:`SECTOR_LSB];
    end
  endfunction

  // Register selected by a bus byte address; one decoder for both bus directions
  function [1:0] reg_sel;
    input [31:0] addr;
    begin
      if (addr == reg_addr(`IDX_CMD_STATUS)) begin
        reg_sel = SEL_CMD;
      end else if (addr == reg_addr(`IDX_ACCESS_CTL)) begin
        reg_sel = SEL_CTL;
      end else if (addr == reg_addr(`IDX_SECTOR_GUARD)) begin
        reg_sel = SEL_GUARD;
      end else begin
        reg_sel = SEL_NONE;
      end
    end
  endfunction

  reg [1:0] lock_state_q;
  reg [1:0] lock_state_d;
  reg [7:0] access_ctl_q;
  reg [7:0] sector_guard_q;
  reg op_start;
  reg [5:0] op_kind;
  reg prog_ok;
  reg prog_bad;
  reg erase_bad;
  reg [31:0] rd_data;
  reg rd_err;
  reg wr_err;
  reg cmd_wr;
  reg actl_wr;
  reg guard_wr;

  wire wr_en;
  wire [31:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire rd_en;
  wire [31:0] rd_addr;
  wire busy;
  wire [5:0] op_field;
  wire erase_done;
  wire [7:0] cmd_byte;
  wire low_lane;
  wire [2:0] page_sector;
  wire [2:0] prog_sector;
  wire [1:0] wr_sel;
  wire [1:0] rd_sel;
  wire page_start;
  wire mass_start;

  assign cmd_byte = wr_data[7:0];
  assign low_lane = wr_strb[0];
  assign page_sector = page_select_in[5:3];
  assign prog_sector = sector_of(prog_addr_in);
  assign wr_sel = reg_sel(wr_addr);
  assign rd_sel = reg_sel(rd_addr);
  assign page_start = op_start && (op_kind == `OP_PAGE_ERASE);
  assign mass_start = op_start && (op_kind == `OP_MASS_ERASE);

  axil_reg_port u_port (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .awaddr_in(awaddr_in),
    .awvalid_in(awvalid_in),
    .awready_out(awready_out),
    .wdata_in(wdata_in),
    .wstrb_in(wstrb_in),
    .wvalid_in(wvalid_in),
    .wready_out(wready_out),
    .bresp_out(bresp_out),
    .bvalid_out(bvalid_out),
    .bready_in(bready_in),
    .araddr_in(araddr_in),
    .arvalid_in(arvalid_in),
    .arready_out(arready_out),
    .rdata_out(rdata_out),
    .rresp_out(rresp_out),
    .rvalid_out(rvalid_out),
    .rready_in(rready_in),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_err_in(wr_err),
    .rd_en_out(rd_en),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_err_in(rd_err)
  );

  flash_op_tracker u_tracker (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .start_in(op_start),
    .kind_in(op_kind),
    .done_in(flash_done_in),
    .busy_out(busy),
    .op_field_out(op_field),
    .erase_done_out(erase_done)
  );

  // Write address decode
  always @* begin
    cmd_wr = 1'b0;
    actl_wr = 1'b0;
    guard_wr = 1'b0;
    wr_err = 1'b0;
    if (wr_sel == SEL_CMD) begin
      cmd_wr = wr_en && low_lane;
    end else if (wr_sel == SEL_CTL) begin
      actl_wr = wr_en && low_lane;
    end else if (wr_sel == SEL_GUARD) begin
      guard_wr = wr_en && low_lane;
    end else begin
      wr_err = 1'b1;
    end
  end

  // Read decode: pure function of the address and the stored state, so reads never disturb state
  always @* begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (rd_sel == SEL_CMD) begin
      rd_data[`STAT_UNLOCK_BIT] = (lock_state_q == ST_UNLOCKED);
      rd_data[`STAT_RSVD_BIT] = 1'b0;
      rd_data[5:0] = op_field;
    end else if (rd_sel == SEL_CTL) begin
      rd_data[7:0] = access_ctl_q;
    end else if (rd_sel == SEL_GUARD) begin
      rd_data[7:0] = sector_guard_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  // Command sequencing; commands arriving while an operation runs are ignored
  always @* begin
    lock_state_d = lock_state_q;
    op_start = 1'b0;
    op_kind = `OP_IDLE;
    erase_bad = 1'b0;
    prog_ok = 1'b0;
    prog_bad = 1'b0;
    if (cmd_wr && !busy) begin
      case (lock_state_q)
        ST_LOCKED: begin
          if (cmd_byte == `CMD_UNLOCK_FIRST) begin
            lock_state_d = ST_FIRST_SEEN;
          end
        end
        ST_FIRST_SEEN: begin
          if (cmd_byte == `CMD_UNLOCK_SECOND) begin
            lock_state_d = ST_UNLOCKED;
          end else begin
            lock_state_d = ST_LOCKED;
          end
        end
        ST_UNLOCKED: begin
          if (cmd_byte == `CMD_PAGE_ERASE) begin
            if (sector_guard_q[page_sector]) begin
              erase_bad = 1'b1;
              lock_state_d = ST_LOCKED;
            end else begin
              op_start = 1'b1;
              op_kind = `OP_PAGE_ERASE;
            end
          end else if (cmd_byte == `CMD_MASS_ERASE) begin
            // A mass erase would wipe guarded sectors too, so any guard refuses it
            if (sector_guard_q != 8'h00) begin
              erase_bad = 1'b1;
              lock_state_d = ST_LOCKED;
            end else begin
              op_start = 1'b1;
              op_kind = `OP_MASS_ERASE;
            end
          end else begin
            lock_state_d = ST_LOCKED;
          end
        end
        default: begin
          lock_state_d = ST_LOCKED;
        end
      endcase
    end else if (prog_req_in && !busy && !cmd_wr) begin
      if (lock_state_q == ST_UNLOCKED &&
          prog_addr_in[`PAGE_MSB:`PAGE_LSB] == page_select_in &&
          !sector_guard_q[prog_sector]) begin
        prog_ok = 1'b1;
        op_start = 1'b1;
        op_kind = `OP_PROGRAM;
      end else begin
        prog_bad = 1'b1;
      end
    end
    if (erase_done) begin
      lock_state_d = ST_LOCKED;
    end
  end

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_state_q <= ST_LOCKED;
    end else begin
      lock_state_q <= lock_state_d;
    end
  end

  // Only the select bit is stored; the reserved low bits read zero
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      access_ctl_q <= `RST_ACCESS_CTL;
    end else if (actl_wr) begin
      access_ctl_q <= {cmd_byte[`ACTL_AUX_SELECT_BIT], 7'h00};
    end
  end

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sector_guard_q <= `RST_SECTOR_GUARD;
    end else if (guard_wr) begin
      sector_guard_q <= sector_guard_q | cmd_byte;
    end
  end

  // Flash-side outputs, all registered
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      program_start_out <= 1'b0;
      program_addr_out <= 24'h000000;
      prog_refused_out <= 1'b0;
      page_erase_start_out <= 1'b0;
      erase_page_out <= 6'h00;
      mass_erase_start_out <= 1'b0;
      erase_refused_out <= 1'b0;
      aux_area_hit_out <= 1'b0;
      sector_guard_out <= `RST_SECTOR_GUARD;
      unlocked_out <= 1'b0;
    end else begin
      program_start_out <= prog_ok;
      prog_refused_out <= prog_bad;
      if (prog_ok) begin
        program_addr_out <= prog_addr_in;
      end
      page_erase_start_out <= page_start;
      mass_erase_start_out <= mass_start;
      if (page_start) begin
        erase_page_out <= page_select_in;
      end
      erase_refused_out <= erase_bad;
      aux_area_hit_out <= access_ctl_q[`ACTL_AUX_SELECT_BIT] &&
                          (fetch_addr_in <= `AUX_AREA_LAST);
      sector_guard_out <= sector_guard_q;
      unlocked_out <= (lock_state_d == ST_UNLOCKED);
    end
  end
endmodule

/* File: rtl/flash_ctl_defines.vh */
/*
  Shared constants of the flash command and status register block: register indexes,
  command codes, status field patterns, reset values and bus response codes.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef FLASH_CTL_DEFINES_VH
`define FLASH_CTL_DEFINES_VH

// Register indexes as printed; byte address on the bus is four times the index
`define IDX_CMD_STATUS 24'hFFE060
`define IDX_ACCESS_CTL 24'hFFE061
`define IDX_SECTOR_GUARD 24'hFFE062

// Command codes
`define CMD_UNLOCK_FIRST 8'h73
`define CMD_UNLOCK_SECOND 8'h8C
`define CMD_PAGE_ERASE 8'h95
`define CMD_MASS_ERASE 8'h63
`define CMD_LOCK 8'h00

// Status register layout
`define STAT_UNLOCK_BIT 7
`define STAT_RSVD_BIT 6
`define OP_IDLE 6'h00
`define OP_PROGRAM 6'h08
`define OP_PAGE_ERASE 6'h10
`define OP_MASS_ERASE 6'h20

// Access control layout
`define ACTL_AUX_SELECT_BIT 7

// Reset values
`define RST_ACCESS_CTL 8'h00
`define RST_SECTOR_GUARD 8'h00

// Auxiliary area window in program space
`define AUX_AREA_LAST 24'h00007F

// Program address fields: page and sector
`define PAGE_MSB 16
`define PAGE_LSB 11
`define SECTOR_MSB 16
`define SECTOR_LSB 14

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: rtl/axil_reg_port.v */
/*
  AXI4-Lite slave front end: takes one write and one read at a time, hands a one-cycle
  write strobe and a read strobe to the register logic, and returns its answers.
  Assumes the register logic answers read data and errors combinationally.
*/
`timescale 1ns/1ns
`include "flash_ctl_defines.vh"
module axil_reg_port (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire [31:0] awaddr_in,
  input wire awvalid_in,
  output reg awready_out,
  input wire [31:0] wdata_in,
  input wire [3:0] wstrb_in,
  input wire wvalid_in,
  output reg wready_out,
  output reg [1:0] bresp_out,
  output reg bvalid_out,
  input wire bready_in,
  input wire [31:0] araddr_in,
  input wire arvalid_in,
  output reg arready_out,
  output reg [31:0] rdata_out,
  output reg [1:0] rresp_out,
  output reg rvalid_out,
  input wire rready_in,
  output wire wr_en_out,
  output reg [31:0] wr_addr_out,
  output reg [31:0] wr_data_out,
  output reg [3:0] wr_strb_out,
  input wire wr_err_in,
  output wire rd_en_out,
  output wire [31:0] rd_addr_out,
  input wire [31:0] rd_data_in,
  input wire rd_err_in
);
  // Both halves held and no response pending: perform the write this cycle
  assign wr_en_out = !awready_out && !wready_out && !bvalid_out;
  assign rd_en_out = arvalid_in && arready_out;
  assign rd_addr_out = araddr_in;

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      awready_out <= 1'b1;
      wready_out <= 1'b1;
      bvalid_out <= 1'b0;
      bresp_out <= `RESP_OKAY;
      wr_addr_out <= 32'h0000_0000;
      wr_data_out <= 32'h0000_0000;
      wr_strb_out <= 4'h0;
    end else begin
      if (awvalid_in && awready_out) begin
        awready_out <= 1'b0;
        wr_addr_out <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        wready_out <= 1'b0;
        wr_data_out <= wdata_in;
        wr_strb_out <= wstrb_in;
      end
      if (wr_en_out) begin
        bvalid_out <= 1'b1;
        bresp_out <= wr_err_in ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
        awready_out <= 1'b1;
        wready_out <= 1'b1;
      end
    end
  end

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      rresp_out <= `RESP_OKAY;
    end else if (rd_en_out) begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b1;
      rdata_out <= rd_data_in;
      rresp_out <= rd_err_in ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid_out && rready_in) begin
      rvalid_out <= 1'b0;
      arready_out <= 1'b1;
    end
  end
endmodule

/* File: rtl/flash_op_tracker.v */
/*
  Tracks the one flash operation under way and its status field pattern.
  Assumes the array raises its done input once per started operation, on the same clock.
*/
`timescale 1ns/1ns
`include "flash_ctl_defines.vh"
module flash_op_tracker (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire start_in,
  input wire [5:0] kind_in,
  input wire done_in,
  output reg busy_out,
  output reg [5:0] op_field_out,
  output reg erase_done_out
);
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_out <= 1'b0;
      op_field_out <= `OP_IDLE;
      erase_done_out <= 1'b0;
    end else begin
      erase_done_out <= 1'b0;
      if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        op_field_out <= kind_in;
      end else if (busy_out && done_in) begin
        busy_out <= 1'b0;
        op_field_out <= `OP_IDLE;
        erase_done_out <= (op_field_out == `OP_PAGE_ERASE);
      end
    end
  end
endmodule

/* File: verification/flash_regs_sva.sv */
/*
  Checker for the flash command and status register block.
  Assumes binding to the top module; sees only its ports.
*/
`timescale 1ns/1ns
module flash_regs_sva (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire [31:0] awaddr_in,
  input wire awvalid_in,
  input wire awready_out,
  input wire [31:0] wdata_in,
  input wire wvalid_in,
  input wire wready_out,
  input wire bvalid_out,
  input wire [31:0] araddr_in,
  input wire arvalid_in,
  input wire arready_out,
  input wire [31:0] rdata_out,
  input wire rvalid_out,
  input wire [5:0] page_select_in,
  input wire [23:0] fetch_addr_in,
  input wire flash_done_in,
  input wire program_start_out,
  input wire [23:0] program_addr_out,
  input wire page_erase_start_out,
  input wire mass_erase_start_out,
  input wire aux_area_hit_out,
  input wire [7:0] sector_guard_out,
  input wire unlocked_out
);
  localparam [31:0] CMD_ADDR = 32'h03FF8180;
  reg [31:0] aw_q;
  reg [7:0] wd_q;
  reg [31:0] ar_q;
  reg busy_q;
  reg pe_q;
  wire cmd_w = (aw_q == CMD_ADDR);
  wire listed = (wd_q == 8'h73) || (wd_q == 8'h8C) || (wd_q == 8'h95) || (wd_q == 8'h63);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Commands written while busy are ignored, so the relock check skips them
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_q <= 32'h0;
      wd_q <= 8'h0;
      ar_q <= 32'h0;
      busy_q <= 1'h0;
      pe_q <= 1'h0;
    end else begin
      if (awvalid_in && awready_out) aw_q <= awaddr_in;
      if (wvalid_in && wready_out) wd_q <= wdata_in[7:0];
      if (arvalid_in && arready_out) ar_q <= araddr_in;
      if (flash_done_in) begin
        busy_q <= 1'h0;
        pe_q <= 1'h0;
      end else if (program_start_out || page_erase_start_out || mass_erase_start_out) begin
        busy_q <= 1'h1;
        pe_q <= page_erase_start_out;
      end
    end
  end
  property p_unlock_pair;
    $rose(unlocked_out) |-> $rose(bvalid_out) && cmd_w && wd_q == 8'h8C;
  endproperty
  a_unlock_pair: assert property (p_unlock_pair) else $error("unlock without code");
  property p_relock_cmd;
    $rose(bvalid_out) && cmd_w && !busy_q && !listed |-> !unlocked_out;
  endproperty
  a_relock_cmd: assert property (p_relock_cmd) else $error("stray code kept unlock");
  property p_page_start;
    page_erase_start_out |-> cmd_w && wd_q == 8'h95 && $past(unlocked_out, 2);
  endproperty
  a_page_start: assert property (p_page_start) else $error("bad page erase start");
  property p_mass_start;
    mass_erase_start_out |-> cmd_w && wd_q == 8'h63 && $past(unlocked_out, 2);
  endproperty
  a_mass_start: assert property (p_mass_start) else $error("bad mass erase start");
  property p_guard_sticky;
    (sector_guard_out & $past(sector_guard_out)) == $past(sector_guard_out);
  endproperty
  a_guard_sticky: assert property (p_guard_sticky) else $error("guard bit cleared");
  property p_prog_guard;
    program_start_out |-> !sector_guard_out[program_addr_out[16:14]]
      && program_addr_out[16:11] == page_select_in;
  endproperty
  a_prog_guard: assert property (p_prog_guard) else $error("guarded program started");
  property p_page_relock;
    flash_done_in && pe_q |-> ##[1:2] !unlocked_out;
  endproperty
  a_page_relock: assert property (p_page_relock) else $error("no relock after erase");
  property p_status_bit;
    $rose(rvalid_out) && ar_q == CMD_ADDR |-> rdata_out[7] == $past(unlocked_out);
  endproperty
  a_status_bit: assert property (p_status_bit) else $error("status bit 7 wrong");
  property p_status_rsvd;
    rvalid_out && ar_q == CMD_ADDR |-> rdata_out[31:8] == 24'h0 && !rdata_out[6];
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("reserved bits set");
  property p_reset_lock;
    $rose(rst_b_in) |-> !unlocked_out;
  endproperty
  a_reset_lock: assert property (p_reset_lock) else $error("unlocked after reset");
  property p_aux_map;
    aux_area_hit_out |-> $past(fetch_addr_in) <= 24'h00007F;
  endproperty
  a_aux_map: assert property (p_aux_map) else $error("aux hit outside window");
  c_page: cover property (page_erase_start_out);
  c_mass: cover property (mass_erase_start_out);
  c_prog: cover property (program_start_out);
endmodule
bind flash_command_status_regs flash_regs_sva flash_regs_sva_i (.*);

/* File: verification/test_flash_command_status_regs.sv */
/*
  Self-checking bench for the flash command and status register block.
  Assumes the checker is bound to the design and a 250 MHz core clock.
*/
`timescale 1ns/1ns
module test_flash_command_status_regs;
  localparam [31:0] A_CMD = 32'h03FF8180;
  localparam [31:0] A_CTL = 32'h03FF8184;
  localparam [31:0] A_GRD = 32'h03FF8188;
  logic core_clk_in = 1'h0, rst_b_in = 1'h0, awvalid_in = 1'h0, wvalid_in = 1'h0;
  logic arvalid_in = 1'h0, bready_in = 1'h1, rready_in = 1'h1;
  logic prog_req_in = 1'h0, flash_done_in = 1'h0;
  logic [31:0] awaddr_in = 32'h0, wdata_in = 32'h0, araddr_in = 32'h0;
  logic [3:0] wstrb_in = 4'hF;
  logic [5:0] page_select_in = 6'h09;
  logic [23:0] prog_addr_in = 24'h0, fetch_addr_in = 24'h0;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, unlocked_out;
  logic program_start_out, prog_refused_out, page_erase_start_out, mass_erase_start_out;
  logic erase_refused_out, aux_area_hit_out;
  logic [1:0] bresp_out, rresp_out;
  logic [31:0] rdata_out;
  logic [23:0] program_addr_out;
  logic [5:0] erase_page_out;
  logic [7:0] sector_guard_out;
  int fails = 0;
  int check_count = 0;
  flash_command_status_regs flash_command_status_regs_i (.*);
  initial forever #2 core_clk_in = ~core_clk_in;
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task hang;
    fails++;
    $display("mismatch handshake wait ran out");
    tally_and_finish;
  endtask
  task wr(input [31:0] a, input [7:0] d, input [1:0] er);
    int n;
    logic b;
    b = 1'h0;
    awaddr_in <= a;
    wdata_in <= {24'h0, d};
    awvalid_in <= 1'h1;
    wvalid_in <= 1'h1;
    for (n = 0; n < 40 && !b; n++) begin
      @(posedge core_clk_in);
      if (awready_out) awvalid_in <= 1'h0;
      if (wready_out) wvalid_in <= 1'h0;
      b = bvalid_out;
    end
    if (!b) hang;
    chk("write response", {30'h0, er}, {30'h0, bresp_out});
  endtask
  task rd(input [31:0] a, input [31:0] exp, input [1:0] er);
    int n;
    logic r;
    r = 1'h0;
    araddr_in <= a;
    arvalid_in <= 1'h1;
    for (n = 0; n < 40 && !r; n++) begin
      @(posedge core_clk_in);
      if (arready_out) arvalid_in <= 1'h0;
      r = rvalid_out;
    end
    if (!r) hang;
    chk("read data", exp, rdata_out);
    chk("read response", {30'h0, er}, {30'h0, rresp_out});
  endtask
  task unlock;
    wr(A_CMD, 8'h73, 2'h0);
    wr(A_CMD, 8'h8C, 2'h0);
  endtask
  // Completion clears the field on the next edge; after a page erase it relocks one edge later
  task finish_op;
    flash_done_in <= 1'h1;
    @(posedge core_clk_in);
    flash_done_in <= 1'h0;
    repeat (3) @(posedge core_clk_in);
  endtask
  // Start and refusal pulses stand for one cycle, so they are looked at on the next edge
  task prog_word(input ok);
    prog_addr_in <= {7'h00, 6'h09, 11'h004};
    prog_req_in <= 1'h1;
    @(posedge core_clk_in);
    prog_req_in <= 1'h0;
    @(posedge core_clk_in);
    chk("program start", {31'h0, ok}, {31'h0, program_start_out});
    chk("program refused", {31'h0, !ok}, {31'h0, prog_refused_out});
    if (ok) chk("program address", 32'h0000_4804, {8'h00, program_addr_out});
    @(posedge core_clk_in);
  endtask
  task aux_at(input [23:0] fa, input [31:0] exp);
    fetch_addr_in <= fa;
    repeat (3) @(posedge core_clk_in);
    chk("aux hit", exp, {31'h0, aux_area_hit_out});
  endtask
  logic [7:0] bad [4] = '{8'h55, 8'h8C, 8'h73, 8'hFF};
  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_b_in <= 1'h1;
    @(posedge core_clk_in);
    rd(A_CMD, 32'h00, 2'h0);
    rd(A_CTL, 32'h00, 2'h0);
    rd(A_GRD, 32'h00, 2'h0);
    rd(32'h03FF818C, 32'h00, 2'h2);
    wr(32'h03FF818C, 8'h01, 2'h2);
    wr(A_CMD, 8'h73, 2'h0);
    rd(A_CMD, 32'h00, 2'h0);
    wr(A_CMD, 8'h8C, 2'h0);
    rd(A_CMD, 32'h80, 2'h0);
    wr(A_CMD, 8'h00, 2'h0);
    rd(A_CMD, 32'h00, 2'h0);
    foreach (bad[i]) begin
      unlock();
      wr(A_CMD, bad[i], 2'h0);
      rd(A_CMD, 32'h00, 2'h0);
    end
    wr(A_CMD, 8'h73, 2'h0);
    wr(A_CMD, 8'h95, 2'h0);
    wr(A_CMD, 8'h8C, 2'h0);
    rd(A_CMD, 32'h00, 2'h0);
    unlock();
    wr(A_CMD, 8'h95, 2'h0);
    chk("page erase start", 32'h1, {31'h0, page_erase_start_out});
    chk("erase page", 32'h09, {26'h0, erase_page_out});
    rd(A_CMD, 32'h90, 2'h0);
    // A command written while the erase runs is ignored
    wr(A_CMD, 8'h00, 2'h0);
    rd(A_CMD, 32'h90, 2'h0);
    finish_op();
    rd(A_CMD, 32'h00, 2'h0);
    unlock();
    wr(A_CMD, 8'h63, 2'h0);
    chk("mass erase start", 32'h1, {31'h0, mass_erase_start_out});
    rd(A_CMD, 32'hA0, 2'h0);
    finish_op();
    rd(A_CMD, 32'h80, 2'h0);
    prog_word(1'h1);
    rd(A_CMD, 32'h88, 2'h0);
    finish_op();
    rd(A_CMD, 32'h80, 2'h0);
    wr(A_CMD, 8'h00, 2'h0);
    prog_word(1'h0);
    wr(A_CTL, 8'h80, 2'h0);
    rd(A_CTL, 32'h80, 2'h0);
    aux_at(24'h00007F, 32'h1);
    aux_at(24'h000080, 32'h0);
    wr(A_CTL, 8'h00, 2'h0);
    aux_at(24'h000010, 32'h0);
    wr(A_GRD, 8'h05, 2'h0);
    wr(A_GRD, 8'h02, 2'h0);
    wr(A_GRD, 8'h00, 2'h0);
    rd(A_GRD, 32'h07, 2'h0);
    // Byte lane 0 disabled: the write is answered but changes nothing
    wstrb_in <= 4'hE;
    wr(A_GRD, 8'hF8, 2'h0);
    wstrb_in <= 4'hF;
    rd(A_GRD, 32'h07, 2'h0);
    chk("guard copy", 32'h07, {24'h0, sector_guard_out});
    unlock();
    wr(A_CMD, 8'h95, 2'h0);
    chk("erase refused", 32'h1, {31'h0, erase_refused_out});
    rd(A_CMD, 32'h00, 2'h0);
    unlock();
    prog_word(1'h0);
    rd(A_CMD, 32'h80, 2'h0);
    wr(A_CMD, 8'h63, 2'h0);
    chk("erase refused", 32'h1, {31'h0, erase_refused_out});
    rd(A_CMD, 32'h00, 2'h0);
    tally_and_finish;
  end
endmodule
